//--- rtl/xgpio_pkg.sv
// package for the extended general pin block: offsets, fields, reset values
// assumes a 32-bit avalon-mm slave whose address is compared directly with byte offsets
`default_nettype none
package xgpio_pkg;
    localparam int unsigned AW = 12;
    localparam logic [11:0] GEN_OFS  = 12'h300;
    localparam logic [11:0] DED_OFS  = 12'h304;
    // general register fields
    localparam int unsigned GEN_OCLR = 0;
    localparam int unsigned GEN_OSET = 3;
    localparam int unsigned GEN_ECLR = 6;
    localparam int unsigned GEN_ESET = 9;
    localparam int unsigned GEN_IN   = 12;
    // dedicated register fields
    localparam int unsigned DED_OCLR = 0;
    localparam int unsigned DED_OSET = 3;
    localparam int unsigned DED_ECLR = 8;
    localparam int unsigned DED_ESET = 11;
    localparam int unsigned DED_IN   = 16;
    localparam logic [2:0]  PIN_RST  = 3'h0;
    localparam logic [31:0] RD_RST   = 32'h0;

    typedef struct packed {
        logic [2:0] dout;
        logic [2:0] oe;
    } xgpio_pins_s;

    typedef struct packed {
        logic [2:0] clr_d;
        logic [2:0] set_d;
        logic [2:0] clr_e;
        logic [2:0] set_e;
    } xgpio_cmd_s;
endpackage
`default_nettype wire

//--- rtl/xgpio_sync.sv
// two-stage synchroniser for a 3-bit input group
// assumes nothing beyond the single device clock
`default_nettype none
module xgpio_sync
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_sys_rst,
    input  wire logic [2:0] i_async,
    output logic      [2:0] o_sync
);
    logic [2:0] meta_q;
    logic [2:0] sync_q;

    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            meta_q <= xgpio_pkg::PIN_RST;
            sync_q <= xgpio_pkg::PIN_RST;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule // xgpio_sync

//--- rtl/xgpio_bank.sv
// three output and three enable bits driven by set and clear strobes
// assumes strobes are one-cycle pulses from the bus slave
`default_nettype none
module xgpio_bank
(
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_sys_rst,
    input  wire logic                   i_we,
    input  wire xgpio_pkg::xgpio_cmd_s  i_cmd,
    output xgpio_pkg::xgpio_pins_s      o_pins
);
    logic [2:0] dout_q;
    logic [2:0] oe_q;

    // clear first, set second: a bit written both ways ends up set
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_bit
            always_ff @(posedge i_ref_clk or posedge i_sys_rst)
            begin
                if (i_sys_rst)
                begin
                    dout_q[g] <= 1'b0;
                    oe_q[g]   <= 1'b0;
                end
                else if (i_we)
                begin
                    if (i_cmd.set_d[g])
                        dout_q[g] <= 1'b1;
                    else if (i_cmd.clr_d[g])
                        dout_q[g] <= 1'b0;
                    if (i_cmd.set_e[g])
                        oe_q[g] <= 1'b1;
                    else if (i_cmd.clr_e[g])
                        oe_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign o_pins.dout = dout_q;
    assign o_pins.oe   = oe_q;
endmodule // xgpio_bank

//--- rtl/xgpio_top.sv
// extended general pin block with avalon-mm register slave
// assumes a single 20 MHz clock; pins sampled through two flops
//
// Operation
// - general reg: 2:0 clears, 5:3 sets output
// - general reg: 8:6 clears, 11:9 sets enable
// - general reg 14:12 reads sampled input pins
// - dedicated register acts only with external arbiter
// - dedicated reg: 2:0 clears, 5:3 sets output
// - dedicated reg: 10:8 clears, 13:11 sets enable
// - dedicated reg 18:16 reads dedicated input levels
// - requests 3:1 feed inputs, outputs drive grants
// - without external arbiter pins keep arbitration role
//
// Chosen here: the Avalon-MM slave port.
`default_nettype none
module xgpio_top
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [11:0] i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_ext_arb_sel,
    input  wire logic [2:0]  i_gen_pin_in,
    output logic      [2:0]  o_gen_pin_out,
    output logic      [2:0]  o_gen_pin_oe_n,
    input  wire logic [2:0]  i_sec_req_n,
    input  wire logic [2:0]  i_arb_gnt_n,
    output logic      [2:0]  o_sec_gnt_n,
    output logic      [2:0]  o_arb_req_n
);
    ////////////////////////////////////////////////////////////////////////
    // bus decode: one wait cycle per access so read data come from a flop
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [2:0]  gen_in_s;
    logic [2:0]  ded_in_s;
    logic [2:0]  sec_req_s;
    logic        arb_q;

    wire acc      = (i_avs_read | i_avs_write) & ~ack_q;
    wire hit_gen  = (i_avs_address == xgpio_pkg::GEN_OFS);
    wire hit_ded  = (i_avs_address == xgpio_pkg::DED_OFS);
    wire wr_take  = i_avs_write & ack_q;
    wire wr_gen   = wr_take & hit_gen;
    wire wr_ded   = wr_take & hit_ded & arb_q;
    // each byte lane that is not enabled masks its write data to zero
    wire [31:0] be_mask;
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++)
        begin : g_lane
            assign be_mask[lane*8 +: 8] = {8{i_avs_byteenable[lane]}};
        end
    endgenerate
    wire [31:0] wd = i_avs_writedata & be_mask;

    ////////////////////////////////////////////////////////////////////////
    // set and clear strobes; reserved bits never reach the banks
    xgpio_pkg::xgpio_cmd_s gen_cmd;
    xgpio_pkg::xgpio_cmd_s ded_cmd;
    assign gen_cmd.clr_d = wd[xgpio_pkg::GEN_OCLR +: 3];
    assign gen_cmd.set_d = wd[xgpio_pkg::GEN_OSET +: 3];
    assign gen_cmd.clr_e = wd[xgpio_pkg::GEN_ECLR +: 3];
    assign gen_cmd.set_e = wd[xgpio_pkg::GEN_ESET +: 3];
    assign ded_cmd.clr_d = wd[xgpio_pkg::DED_OCLR +: 3];
    assign ded_cmd.set_d = wd[xgpio_pkg::DED_OSET +: 3];
    assign ded_cmd.clr_e = wd[xgpio_pkg::DED_ECLR +: 3];
    assign ded_cmd.set_e = wd[xgpio_pkg::DED_ESET +: 3];

    xgpio_pkg::xgpio_pins_s gen_pins;
    xgpio_pkg::xgpio_pins_s ded_pins;

    // zero bits in a write pass no strobe, so the banks hold them
    xgpio_bank u_gen_bank
    (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_we      (wr_gen),
        .i_cmd     (gen_cmd),
        .o_pins    (gen_pins)
    );

    xgpio_bank u_ded_bank
    (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_we      (wr_ded),
        .i_cmd     (ded_cmd),
        .o_pins    (ded_pins)
    );

    ////////////////////////////////////////////////////////////////////////
    // input sampling
    xgpio_sync u_gen_sync
    (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_gen_pin_in),
        .o_sync    (gen_in_s)
    );

    xgpio_sync u_req_sync
    (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_sec_req_n),
        .o_sync    (sec_req_s)
    );

    // request pins are active low as arbitration signals; as inputs
    // they read the raw pin level
    assign ded_in_s = arb_q ? sec_req_s : 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // read mux
    wire [31:0] rd_gen = {17'h0, gen_in_s, 12'h0};
    wire [31:0] rd_ded = {13'h0, ded_in_s, 16'h0};
    wire [31:0] rd_mux = hit_gen ? rd_gen :
                         hit_ded ? rd_ded : xgpio_pkg::RD_RST;

    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            ack_q   <= 1'b0;
            rdata_q <= xgpio_pkg::RD_RST;
            arb_q   <= 1'b0;
        end
        else
        begin
            ack_q   <= acc;
            arb_q   <= i_ext_arb_sel;
            if (acc & i_avs_read)
                rdata_q <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin outputs, all from flops
    logic [2:0] gen_out_q;
    logic [2:0] gen_oe_n_q;
    logic [2:0] sec_gnt_q;
    logic [2:0] arb_req_q;

    // without the external arbiter the internal arbiter owns the pins;
    // a dedicated output whose enable is clear leaves its grant released
    wire [2:0] gnt_d = arb_q ? (ded_pins.dout | ~ded_pins.oe)
                             : i_arb_gnt_n;

    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            gen_out_q  <= 3'h0;
            gen_oe_n_q <= 3'h7;
            sec_gnt_q  <= 3'h7;
            arb_req_q  <= 3'h7;
        end
        else
        begin
            gen_out_q  <= gen_pins.dout;
            gen_oe_n_q <= ~gen_pins.oe;
            sec_gnt_q  <= gnt_d;
            arb_req_q  <= arb_q ? 3'h7 : sec_req_s;
        end
    end

    assign o_avs_readdata    = rdata_q;
    assign o_avs_waitrequest = ~ack_q;
    assign o_gen_pin_out     = gen_out_q;
    assign o_gen_pin_oe_n    = gen_oe_n_q;
    assign o_sec_gnt_n       = sec_gnt_q;
    assign o_arb_req_n       = arb_req_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_gen_set_out: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        wr_gen && gen_cmd.set_d[0] |-> ##2 o_gen_pin_out[0])
        else $error("set did not raise output");

    a_gen_clr_out: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        wr_gen && gen_cmd.clr_d[0] && !gen_cmd.set_d[0]
        |-> ##2 !o_gen_pin_out[0])
        else $error("clear did not drop output");

    a_gen_set_oe: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        wr_gen && gen_cmd.set_e[2] |-> ##2 !o_gen_pin_oe_n[2])
        else $error("enable set missing");

    a_gen_in_read: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        acc && i_avs_read && hit_gen |=>
        rdata_q[14:12] == $past(gen_in_s) && rdata_q[11:0] == 12'h0)
        else $error("general input read wrong");

    a_ded_gated: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        !arb_q |=> $stable(ded_pins.dout))
        else $error("dedicated changed without arbiter");

    a_ded_set_out: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        wr_ded && ded_cmd.set_d[0] |=> ded_pins.dout[0])
        else $error("dedicated set failed");

    a_ded_clr_oe: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        wr_ded && ded_cmd.clr_e[0] && !ded_cmd.set_e[0]
        |=> !ded_pins.oe[0])
        else $error("dedicated enable clear failed");

    a_ded_in_read: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        acc && i_avs_read && hit_ded |=>
        rdata_q[18:16] == $past(ded_in_s) && rdata_q[15:0] == 16'h0)
        else $error("dedicated input read wrong");

    a_gnt_map: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        arb_q |=> o_sec_gnt_n == $past(ded_pins.dout | ~ded_pins.oe))
        else $error("grant pins not mapped");

    a_arb_keep: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        !arb_q |=> o_sec_gnt_n == $past(i_arb_gnt_n))
        else $error("arbitration role lost");

    a_zero_hold: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        wr_gen && gen_cmd == '0 |=> $stable(gen_pins))
        else $error("zero write changed bits");

    a_resv_zero: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        ack_q |-> rdata_q[31:19] == 13'h0)
        else $error("reserved bits not zero");

    a_ded_zero_hold: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        wr_ded && ded_cmd == '0 |=> $stable(ded_pins))
        else $error("zero write changed dedicated bits");

    a_ded_in_off: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        !arb_q |-> ded_in_s == 3'h0)
        else $error("dedicated inputs seen without arbiter");

    a_req_hold: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        arb_q |=> o_arb_req_n == 3'h7)
        else $error("requests leaked to internal arbiter");

    a_req_pass: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        !arb_q |=> o_arb_req_n == $past(sec_req_s))
        else $error("requests not passed to internal arbiter");

    a_unmapped_rd: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        acc && i_avs_read && !hit_gen && !hit_ded |=> rdata_q == 32'h0)
        else $error("unmapped read not zero");

    a_gen_rsvd_rd: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        acc && i_avs_read && hit_gen |=> rdata_q[31:15] == 17'h0)
        else $error("general reserved bits not zero");

    a_gen_out_pin: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        1'b1 |=> o_gen_pin_out == $past(gen_pins.dout))
        else $error("output pins do not follow bank");

    a_gen_oe_pin: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        1'b1 |=> o_gen_pin_oe_n == ~$past(gen_pins.oe))
        else $error("enable pins do not follow bank");

    a_wait_pulse: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        !o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    ////////////////////////////////////////////////////////////////////////
    // per-bit set, clear and hold of both banks
    genvar b;
    generate
        for (b = 0; b < 3; b++)
        begin : g_bit_chk
            a_gen_out_set: assert property (@(posedge i_ref_clk)
                disable iff (i_sys_rst)
                wr_gen && gen_cmd.set_d[b] |=> gen_pins.dout[b])
                else $error("general output set failed");

            a_gen_out_clr: assert property (@(posedge i_ref_clk)
                disable iff (i_sys_rst)
                wr_gen && gen_cmd.clr_d[b] && !gen_cmd.set_d[b]
                |=> !gen_pins.dout[b])
                else $error("general output clear failed");

            a_gen_oe_set: assert property (@(posedge i_ref_clk)
                disable iff (i_sys_rst)
                wr_gen && gen_cmd.set_e[b] |=> gen_pins.oe[b])
                else $error("general enable set failed");

            a_gen_oe_clr: assert property (@(posedge i_ref_clk)
                disable iff (i_sys_rst)
                wr_gen && gen_cmd.clr_e[b] && !gen_cmd.set_e[b]
                |=> !gen_pins.oe[b])
                else $error("general enable clear failed");

            a_gen_bit_hold: assert property (@(posedge i_ref_clk)
                disable iff (i_sys_rst)
                !(wr_gen && (gen_cmd.set_d[b] || gen_cmd.clr_d[b]))
                |=> $stable(gen_pins.dout[b]))
                else $error("general output changed unasked");

            a_ded_out_set: assert property (@(posedge i_ref_clk)
                disable iff (i_sys_rst)
                wr_ded && ded_cmd.set_d[b] |=> ded_pins.dout[b])
                else $error("dedicated output set failed");

            a_ded_out_clr: assert property (@(posedge i_ref_clk)
                disable iff (i_sys_rst)
                wr_ded && ded_cmd.clr_d[b] && !ded_cmd.set_d[b]
                |=> !ded_pins.dout[b])
                else $error("dedicated output clear failed");

            a_ded_oe_set: assert property (@(posedge i_ref_clk)
                disable iff (i_sys_rst)
                wr_ded && ded_cmd.set_e[b] |=> ded_pins.oe[b])
                else $error("dedicated enable set failed");

            a_ded_oe_clr: assert property (@(posedge i_ref_clk)
                disable iff (i_sys_rst)
                wr_ded && ded_cmd.clr_e[b] && !ded_cmd.set_e[b]
                |=> !ded_pins.oe[b])
                else $error("dedicated enable clear failed");

            a_ded_bit_hold: assert property (@(posedge i_ref_clk)
                disable iff (i_sys_rst)
                !(wr_ded && (ded_cmd.set_d[b] || ded_cmd.clr_d[b]))
                |=> $stable(ded_pins.dout[b]))
                else $error("dedicated output changed unasked");
        end
    endgenerate
endmodule // xgpio_top
`default_nettype wire

//--- verification/xgpio_board.sv
// board model: straps undriven general pins, stands in for the internal
// arbiter; assumes the single device clock and reset of the block
`default_nettype none
module xgpio_board
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_sys_rst,
    input  wire logic [2:0] i_pin_out,
    input  wire logic [2:0] i_pin_oe_n,
    input  wire logic [2:0] i_board_lvl,
    input  wire logic [2:0] i_req_n,
    output logic      [2:0] o_pin,
    output logic      [2:0] o_gnt_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // a released pin shows the board strap, never the last driven level
    assign o_pin = (i_pin_out & ~i_pin_oe_n) | (i_board_lvl & i_pin_oe_n);
    // internal arbiter grants whatever is requested, one cycle late
    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_gnt_n <= 3'h7;
        else
            o_gnt_n <= i_req_n;
    end
endmodule // xgpio_board
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the extended general pin block
// assumes xgpio_pkg, xgpio_top and xgpio_board are compiled first
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] GA = xgpio_pkg::GEN_OFS;
    localparam logic [11:0] DA = xgpio_pkg::DED_OFS;
    logic        clk, rst, rd, wr, ext, wait_r;
    logic [11:0] addr;
    logic [31:0] wd, rdat, q;
    logic [2:0]  pin, gout, oe_n, lvl, sreq_n, agnt_n, sgnt_n, areq_n;
    int          failures, n_checks;

    xgpio_top uut (.i_ref_clk(clk), .i_sys_rst(rst), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wait_r), .i_ext_arb_sel(ext),
        .i_gen_pin_in(pin), .o_gen_pin_out(gout), .o_gen_pin_oe_n(oe_n),
        .i_sec_req_n(sreq_n), .i_arb_gnt_n(agnt_n), .o_sec_gnt_n(sgnt_n),
        .o_arb_req_n(areq_n));
    xgpio_board board (.i_ref_clk(clk), .i_sys_rst(rst), .i_pin_out(gout),
        .i_pin_oe_n(oe_n), .i_board_lvl(lvl), .i_req_n(areq_n),
        .o_pin(pin), .o_gnt_n(agnt_n));

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        for (k = 0; k < 16; k++)
        begin
            @(posedge clk);
            if (wait_r === 1'b0)
                break;
        end
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (k == 16)
        begin
            failures++;
            results();
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("gen_out", 0, gout);
        chk("gen_oe_n", 3'h7, oe_n);
        bus(0, GA, 0);
        chk("gen_rd", 0, q & 32'hfffff000);
        bus(0, DA, 0);
        chk("ded_rd", 0, q & 32'hffffc0c0);
        bus(1, 12'h308, 32'hffffffff);
        bus(0, 12'h308, 0);
        chk("unmapped", 0, q);
        $display("test reset done");
    endtask
    task automatic t_gen_out();
        bus(1, GA, 32'h28);
        bus(1, GA, 32'he00);
        wt(3);
        chk("gen_out", 3'h5, gout);
        chk("gen_oe_n", 0, oe_n);
        bus(1, GA, 32'hffff8001);
        wt(3);
        chk("gen_out", 3'h4, gout);
        bus(1, GA, 0);
        wt(3);
        chk("gen_out", 3'h4, gout);
        bus(1, GA, 32'h80);
        wt(3);
        chk("gen_oe_n", 3'h2, oe_n);
        chk("gen_out", 3'h4, gout);
        bus(0, GA, 0);
        chk("gen_rsvd", 0, q & 32'hffff8000);
        $display("test general outputs done");
    endtask
    task automatic t_gen_in();
        // bit 1 released and strapped high, bits 2 and 0 driven 1 and 0
        lvl <= 3'h3;
        wt(4);
        bus(0, GA, 0);
        chk("gen_in", 32'h6000, q & 32'h7000);
        $display("test general inputs done");
    endtask
    task automatic t_ded_off();
        sreq_n <= 3'h2;
        bus(1, DA, 32'h3838);
        wt(4);
        chk("gnt_pass", 3'h2, sgnt_n);
        chk("req_pass", 3'h2, areq_n);
        bus(0, DA, 0);
        chk("ded_in_off", 0, q & 32'h70000);
        $display("test dedicated idle done");
    endtask
    task automatic t_ded_on();
        ext <= 1'b1;
        sreq_n <= 3'h5;
        wt(4);
        bus(1, DA, 32'h3800);
        wt(3);
        chk("ded_out", 0, sgnt_n);
        chk("req_hold", 3'h7, areq_n);
        bus(1, DA, 32'h18);
        wt(3);
        chk("ded_out", 3'h3, sgnt_n);
        bus(1, DA, 32'hc001);
        wt(3);
        chk("ded_out", 3'h2, sgnt_n);
        bus(1, DA, 32'h100);
        wt(3);
        chk("ded_oe", 3'h3, sgnt_n);
        bus(1, DA, 32'hffffc0c0);
        wt(3);
        chk("ded_rsvd", 3'h3, sgnt_n);
        bus(0, DA, 0);
        chk("ded_in", 32'h50000, q & 32'hffffc0c0);
        ext <= 1'b0;
        wt(5);
        chk("gnt_back", 3'h5, sgnt_n);
        $display("test dedicated active done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        {rst, rd, wr, ext, addr, wd, lvl} = {1'b1, 50'h0};
        sreq_n = 3'h7;
        failures = 0;
        n_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_gen_out();
        t_gen_in();
        t_ded_off();
        t_ded_on();
        results();
    end
endmodule // tb_top
`default_nettype wire
